// file: hw/count_gate_pkg.sv
// Purpose: Constants shared by the scaler count, gate and reset control.
// Assumes: A single 250 MHz system clock.
// Notes:   Times are kept in their own unit; cycle counts derive from them.
package count_gate_pkg;

  // ------------------------------------------------------------------
  // Clock and timing
  // ------------------------------------------------------------------
  localparam int unsigned CLOCK_MHZ        = 250;   // System clock rate
  localparam int unsigned RESET_WINDOW_MS  = 50;    // Nominal one-shot width
  localparam int unsigned RESET_MIN_MS     = 25;    // Shortest acceptable width
  // Nominal time, exact product: 50 ms at 250 MHz
  localparam int unsigned RESET_WINDOW_CYC = RESET_WINDOW_MS * CLOCK_MHZ * 1000;
  localparam int unsigned RESET_CNT_W      = 24;    // Holds 12,500,000

  // ------------------------------------------------------------------
  // Divider select encodings
  // ------------------------------------------------------------------
  localparam logic [1:0] DIV_BY_1 = 2'h0;           // Straight through
  localparam logic [1:0] DIV_BY_2 = 2'h1;           // Second stage only
  localparam logic [1:0] DIV_BY_4 = 2'h2;           // Both stages

  // ------------------------------------------------------------------
  // Decade count and interrupt layout
  // ------------------------------------------------------------------
  localparam int unsigned DECADES     = 7;          // Interrogation inputs
  localparam int unsigned DECADE_SEL_W = 3;         // Decade select width
  localparam int unsigned INT_W       = 4;          // Event bits
  localparam int unsigned EV_PRESET   = 0;          // Preset pulse seen
  localparam int unsigned EV_STOPPED  = 1;          // Entered stop
  localparam int unsigned EV_CLEAR    = 2;          // Counter clear issued
  localparam int unsigned EV_STROBE   = 3;          // Printer strobe issued
  localparam logic [INT_W-1:0] INT_RESET = 4'h0;    // Status and mask reset

  // ------------------------------------------------------------------
  // Register map (word offsets as byte addresses)
  // ------------------------------------------------------------------
  localparam int unsigned ADDR_W     = 4;
  localparam logic [ADDR_W-1:0] REG_CONTROL = 4'h0; // Switches and commands
  localparam logic [ADDR_W-1:0] REG_STATUS  = 4'h4; // Run state, stage bits
  localparam logic [ADDR_W-1:0] REG_INT_ST  = 4'h8; // Sticky events, W1C
  localparam logic [ADDR_W-1:0] REG_INT_MSK = 4'hC; // Event mask
  // Control fields
  localparam int unsigned CTL_DIV_LO  = 0;          // Divider select [1:0]
  localparam int unsigned CTL_DIV_HI  = 1;
  localparam int unsigned CTL_DEC_LO  = 2;          // Decade select [4:2]
  localparam int unsigned CTL_DEC_HI  = 4;
  localparam int unsigned CTL_STOPSW  = 5;          // Stop-on-preset switch
  localparam int unsigned CTL_START   = 8;          // Write 1: start pulse
  localparam int unsigned CTL_STOP    = 9;          // Write 1: stop pulse
  localparam int unsigned CTL_RESET   = 10;         // Write 1: reset request
  localparam logic [5:0] CTL_RESET_VAL = 6'h00;     // Ratio 1, decade 0, open
  // Status fields
  localparam int unsigned ST_RUN      = 0;          // Run state
  localparam int unsigned ST_WINDOW   = 1;          // Reset window active
  localparam int unsigned ST_STAGE1   = 2;          // First stage bit
  localparam int unsigned ST_STAGE2   = 3;          // Second stage bit

endpackage

// file: hw/count_gate_reset_control.sv
// Purpose: Prescaler, start-stop gate, reset one-shot and printer strobe.
// Assumes: Pulse inputs come from outside the clock domain.
// Notes:   One clock, synchronous active-high reset, global clock enable.
//
// Decided for this implementation: the register addresses and strobed register access.
`timescale 1ns/10ps
`default_nettype none

// ------------------------------------------------------------------
// Two-flop synchroniser with rising-edge strobe
// ------------------------------------------------------------------
module pulse_sync_edge (
  // Clocking
  input  wire logic clock,
  input  wire logic srst,
  input  wire logic clk_en,
  // Pulse
  input  wire logic async_in,
  output logic      rise
);
  logic meta_r;   // First flop, read only by sync_r
  logic sync_r;   // Settled level
  logic last_r;   // Previous settled level
  // Idle level is low, so no false edge after reset

  // Sync chain and history
  always_ff @(posedge clock) begin
    if (srst) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      last_r <= 1'b0;
    end else if (clk_en) begin
      meta_r <= async_in;
      sync_r <= meta_r;
      last_r <= sync_r;
    end
  end

  // One-cycle strobe on a settled rising edge
  assign rise = clk_en & sync_r & ~last_r;
endmodule

// ------------------------------------------------------------------
// Divide-by-two stage
// ------------------------------------------------------------------
module div2_stage (
  // Clocking
  input  wire logic clock,
  input  wire logic srst,
  input  wire logic clk_en,
  // Counter clear
  input  wire logic clear,
  // Pulses
  input  wire logic in_pulse,
  output logic      out_pulse,
  output logic      state
);
  logic half_r;   // Toggle state

  // Toggle on each pulse, back to zero on clear
  always_ff @(posedge clock) begin
    if (srst || (clk_en && clear)) begin
      half_r <= 1'b0;
    end else if (clk_en && in_pulse) begin
      half_r <= ~half_r;
    end
  end

  // Carry out on the second pulse of each pair
  assign out_pulse = clk_en & in_pulse & half_r;
  assign state     = half_r;
endmodule

// ------------------------------------------------------------------
// Top level
// ------------------------------------------------------------------
module count_gate_reset_control #(
  // Window length in cycles; a bench may shorten it
  parameter int unsigned WINDOW_CYC = count_gate_pkg::RESET_WINDOW_CYC
) (
  // Clock and reset
  input  wire logic                    clock,
  input  wire logic                    srst,
  input  wire logic                    clk_en,
  // Register port
  input  wire logic [3:0]              reg_addr,
  input  wire logic [31:0]             reg_wdata,
  input  wire logic                    reg_write,
  input  wire logic                    reg_read,
  output logic [31:0]                  reg_rdata,
  // Decade chain outputs
  input  wire logic [7:0]              decade_out,
  input  wire logic [6:0]              interrogate_in,
  // External control pulses
  input  wire logic                    start_input_socket,
  input  wire logic                    stop_input_socket,
  input  wire logic                    reset_input_socket_a,
  input  wire logic                    reset_input_socket_b,
  // Outputs to the rest of the scaler
  output logic                         preset_count_output,
  output logic                         input_inhibit,
  output logic                         counter_clear_a,
  output logic                         counter_clear_b,
  output logic                         printer_strobe,
  output logic                         irq
);

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  logic [1:0]                    divider_select_switch; // Ratio select
  logic [2:0]                    decade_select_switch;  // Chosen decade
  logic                          stop_on_preset_switch; // Closed = stop
  logic [5:0]                    ctl_r;                 // Control bits
  logic [count_gate_pkg::INT_W-1:0] int_st_r;           // Sticky events
  logic [count_gate_pkg::INT_W-1:0] int_msk_r;          // Enables
  logic [31:0]                   rdata_r;               // Read data
  logic                          start_stop_state;      // 1 = running
  logic                          window_r;              // One-shot active
  logic [count_gate_pkg::RESET_CNT_W-1:0] win_cnt_r;    // Window counter
  logic                          clear_r;               // Clear pulse
  logic                          preset_r;              // Gated preset out
  logic                          strobe_r;              // Printer strobe

  // Field slices of the stored control word
  assign divider_select_switch = ctl_r[count_gate_pkg::CTL_DIV_HI:count_gate_pkg::CTL_DIV_LO];
  assign decade_select_switch  = ctl_r[count_gate_pkg::CTL_DEC_HI:count_gate_pkg::CTL_DEC_LO];
  assign stop_on_preset_switch = ctl_r[count_gate_pkg::CTL_STOPSW];

  // ------------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------------
  logic       start_rise;  // Start pulse
  logic       stop_rise;   // Stop pulse
  logic       rst_a_rise;  // Reset socket a
  logic       rst_b_rise;  // Reset socket b
  logic [7:0] dec_rise;    // Decade output pulses
  logic [6:0] int_rise;    // Interrogation pulses
  // Two cycles from pin to strobe per chain
  // Pulses need one low cycle to stay apart

  pulse_sync_edge u_start (.clock(clock), .srst(srst), .clk_en(clk_en),
    .async_in(start_input_socket), .rise(start_rise));
  pulse_sync_edge u_stop (.clock(clock), .srst(srst), .clk_en(clk_en),
    .async_in(stop_input_socket), .rise(stop_rise));
  pulse_sync_edge u_rsta (.clock(clock), .srst(srst), .clk_en(clk_en),
    .async_in(reset_input_socket_a), .rise(rst_a_rise));
  pulse_sync_edge u_rstb (.clock(clock), .srst(srst), .clk_en(clk_en),
    .async_in(reset_input_socket_b), .rise(rst_b_rise));

  // Every decade and interrogation line gets its own chain
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_dec
      pulse_sync_edge u_dec (.clock(clock), .srst(srst), .clk_en(clk_en),
        .async_in(decade_out[gi]), .rise(dec_rise[gi]));
    end
    for (gi = 0; gi < count_gate_pkg::DECADES; gi++) begin : g_int
      pulse_sync_edge u_int (.clock(clock), .srst(srst), .clk_en(clk_en),
        .async_in(interrogate_in[gi]), .rise(int_rise[gi]));
    end
  endgenerate

  // ------------------------------------------------------------------
  // Register decode
  // ------------------------------------------------------------------
  wire wr_ctl    = clk_en & reg_write & (reg_addr == count_gate_pkg::REG_CONTROL);
  wire wr_int_st = clk_en & reg_write & (reg_addr == count_gate_pkg::REG_INT_ST);
  wire wr_msk    = clk_en & reg_write & (reg_addr == count_gate_pkg::REG_INT_MSK);
  // Status and unmapped writes are dropped
  // Command bits are one-cycle pulses on a control write
  wire sw_start  = wr_ctl & reg_wdata[count_gate_pkg::CTL_START];
  wire sw_stop   = wr_ctl & reg_wdata[count_gate_pkg::CTL_STOP];
  wire sw_reset  = wr_ctl & reg_wdata[count_gate_pkg::CTL_RESET];

  // ------------------------------------------------------------------
  // Prescaler
  // ------------------------------------------------------------------
  // Synchronised edge detection works far beyond 40 kc/s at 250 MHz
  wire sel_pulse = dec_rise[decade_select_switch];
  wire by4       = divider_select_switch == count_gate_pkg::DIV_BY_4;
  wire by2       = divider_select_switch == count_gate_pkg::DIV_BY_2;
  logic stage1_out;  // First stage carry
  logic stage2_out;  // Second stage carry
  logic stage1_bit;  // First stage state
  logic stage2_bit;  // Second stage state
  // Stage bits show in status for diagnosis

  // Only the ratio-four path feeds the first stage
  div2_stage u_stage1 (.clock(clock), .srst(srst), .clk_en(clk_en),
    .clear(clear_r), .in_pulse(sel_pulse & by4),
    .out_pulse(stage1_out), .state(stage1_bit));
  // Second stage takes the first stage's carry or the decade directly
  div2_stage u_stage2 (.clock(clock), .srst(srst), .clk_en(clk_en),
    .clear(clear_r), .in_pulse(by4 ? stage1_out : (sel_pulse & by2)),
    .out_pulse(stage2_out), .state(stage2_bit));

  // Ratio one bypasses both stages
  wire preset_pulse = (by4 | by2) ? stage2_out : sel_pulse;

  // ------------------------------------------------------------------
  // Start-stop gate
  // ------------------------------------------------------------------
  wire reset_req    = rst_a_rise | rst_b_rise | sw_reset;
  wire win_start    = clk_en & reset_req & ~window_r;
  wire win_end      = clk_en & window_r &
    (win_cnt_r == count_gate_pkg::RESET_CNT_W'(WINDOW_CYC - 1));
  wire preset_stop  = preset_pulse & stop_on_preset_switch;
  wire go_stop      = stop_rise | sw_stop | preset_stop | win_start;
  wire go_run       = start_rise | sw_start;
  // Gate only open while running, never during the window
  wire gate_open    = start_stop_state & ~window_r & ~stop_on_preset_switch;

  // Stop wins over a simultaneous start: stopping is the safe side
  // A start in the window is kept; gate stays shut
  always_ff @(posedge clock) begin
    if (srst) begin
      start_stop_state <= 1'b0;
    end else if (clk_en) begin
      if (go_stop) begin
        start_stop_state <= 1'b0;
      end else if (go_run) begin
        start_stop_state <= 1'b1;
      end
    end
  end

  assign input_inhibit = ~start_stop_state;

  // Preset output and printer strobe, both registered
  always_ff @(posedge clock) begin
    if (srst) begin
      preset_r <= 1'b0;
      strobe_r <= 1'b0;
    end else if (clk_en) begin
      preset_r <= preset_pulse & gate_open;
      strobe_r <= |int_rise;
    end
  end

  assign preset_count_output = preset_r;
  // Each decade has its own one-way chain, so nothing flows back
  assign printer_strobe      = strobe_r;

  // ------------------------------------------------------------------
  // Reset one-shot
  // ------------------------------------------------------------------
  // Retriggers during the window are ignored, like the monostable
  // Count 0 to WINDOW_CYC-1, then clear next cycle
  // Window length is exactly WINDOW_CYC cycles
  always_ff @(posedge clock) begin
    if (srst) begin
      window_r  <= 1'b0;
      win_cnt_r <= '0;
      clear_r   <= 1'b0;
    end else if (clk_en) begin
      clear_r <= win_end;
      if (win_start) begin
        window_r  <= 1'b1;
        win_cnt_r <= '0;
      end else if (win_end) begin
        window_r  <= 1'b0;
      end else if (window_r) begin
        win_cnt_r <= win_cnt_r + 1'b1;
      end
    end
  end

  assign counter_clear_a = clear_r;
  assign counter_clear_b = clear_r;

  // ------------------------------------------------------------------
  // Control, interrupt and read registers
  // ------------------------------------------------------------------
  // Events: preset pre-gate, stop, clear, strobe
  wire [count_gate_pkg::INT_W-1:0] ev = {strobe_r, clear_r,
    go_stop & start_stop_state, preset_pulse};

  // Set wins over a write-one clear
  always_ff @(posedge clock) begin
    if (srst) begin
      ctl_r     <= count_gate_pkg::CTL_RESET_VAL;
      int_st_r  <= count_gate_pkg::INT_RESET;
      int_msk_r <= count_gate_pkg::INT_RESET;
    end else if (clk_en) begin
      if (wr_ctl) begin
        ctl_r <= reg_wdata[5:0];
      end
      if (wr_msk) begin
        int_msk_r <= reg_wdata[count_gate_pkg::INT_W-1:0];
      end
      int_st_r <= (int_st_r & ~({count_gate_pkg::INT_W{wr_int_st}} &
        reg_wdata[count_gate_pkg::INT_W-1:0])) | ev;
    end
  end

  // Read mux; unmapped addresses read zero
  // Command bits are write-only, read zero
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (reg_addr)
      count_gate_pkg::REG_CONTROL: rd_mux = {26'h0, ctl_r};
      count_gate_pkg::REG_STATUS:  rd_mux = {28'h0, stage2_bit, stage1_bit,
                                             window_r, start_stop_state};
      count_gate_pkg::REG_INT_ST:  rd_mux = {28'h0, int_st_r};
      count_gate_pkg::REG_INT_MSK: rd_mux = {28'h0, int_msk_r};
      default:                     rd_mux = 32'h0000_0000;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clock) begin
    if (srst) begin
      rdata_r <= 32'h0000_0000;
    end else if (clk_en) begin
      rdata_r <= reg_read ? rd_mux : 32'h0000_0000;
    end
  end

  assign reg_rdata = rdata_r;
  assign irq       = |(int_st_r & int_msk_r);

endmodule
`default_nettype wire

// file: verif/count_gate_monitor.sv
// Purpose: Pin-level checks on the count, gate and reset control.
// Assumes: Global enable high; the checks rest while it is low.
// Notes:   Delay ranges allow for the two-flop input synchronisers.
`timescale 1ns/10ps
`default_nettype none
module count_gate_monitor (
  // Clock, reset, enable
  input wire logic       clock,
  input wire logic       srst,
  input wire logic       clk_en,
  // Pulse inputs
  input wire logic [6:0] interrogate_in,
  input wire logic       start_input_socket,
  input wire logic       stop_input_socket,
  input wire logic       reset_input_socket_a,
  input wire logic       reset_input_socket_b,
  // Outputs under watch
  input wire logic       preset_count_output,
  input wire logic       input_inhibit,
  input wire logic       counter_clear_a,
  input wire logic       counter_clear_b,
  input wire logic       printer_strobe
);
  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  default clocking @(posedge clock); endclocking
  default disable iff (srst || !clk_en);
  // Gate state one cycle back decides, since the output is registered
  preset_gate_a: assert property (preset_count_output |-> !$past(input_inhibit))
    else $error("preset pulse through closed gate");
  preset_once_a: assert property (preset_count_output |=> !preset_count_output)
    else $error("preset pulse longer than one cycle");
  clear_pair_a: assert property (counter_clear_a |-> counter_clear_b ##1 !counter_clear_a)
    else $error("counter clear outputs disagree");
  strobe_or_a: assert property ($rose(|interrogate_in) |-> ##[2:6] printer_strobe)
    else $error("no strobe after interrogation");
  strobe_once_a: assert property (printer_strobe |=> !printer_strobe)
    else $error("strobe longer than one cycle");
  stop_socket_a: assert property ($rose(stop_input_socket) |-> ##[2:6] input_inhibit)
    else $error("stop socket did not stop");
  // Only a lone start is judged; stop sources win when they coincide
  start_socket_a: assert property (
    $rose(start_input_socket) && !stop_input_socket && !reset_input_socket_a
    && !reset_input_socket_b |-> ##[2:6] !input_inhibit)
    else $error("start socket did not run");
  reset_stop_a: assert property ($rose(reset_input_socket_a) |-> ##[2:6] input_inhibit)
    else $error("reset socket did not stop");
  // Two flops in the path: nothing may change on the next edge
  sync_delay_a: assert property (
    $rose(stop_input_socket) && !input_inhibit |=> !input_inhibit)
    else $error("stop acted before synchronisation");
endmodule
`default_nettype wire

// file: verif/decade_chain_model.sv
// Purpose: Far side: input stage, decade chain and printer controller.
// Assumes: Source pulses arrive shaped; one decade carries them.
// Notes:   Unselected decades stay low so presets have one origin.
`timescale 1ns/10ps
`default_nettype none
module decade_chain_model (
  // Clocking
  input  wire logic       clock,
  input  wire logic       srst,
  // Source pulses and decade choice
  input  wire logic       src_pulse,
  input  wire logic [2:0] decade_sel,
  // From the control block
  input  wire logic       input_inhibit,
  input  wire logic       printer_strobe,
  // Decade outputs to the control block
  output logic      [7:0] decade_out
);
  logic gated;    // Source after the input stage
  logic gated_q;  // Last value, for edge counting
  int   passed;   // Pulses that reached the chain
  int   strobes;  // Strobes taken by the printer side
  // Input stage is blocked while the control block inhibits it
  assign gated      = src_pulse & ~input_inhibit;
  assign decade_out = 8'(gated) << decade_sel;
  // Tallies; a pulse chopped by the inhibit still counts once
  always_ff @(posedge clock) begin
    if (srst) begin
      gated_q <= 1'b0;
      passed  <= 0;
      strobes <= 0;
    end else begin
      gated_q <= gated;
      if (gated && !gated_q) passed <= passed + 1;
      if (printer_strobe === 1'b1) strobes <= strobes + 1;
    end
  end
endmodule
`default_nettype wire

// file: verif/count_gate_reset_control_tb.sv
// Purpose: Self-checking bench for the count, gate and reset control.
// Assumes: A shortened reset window, so its end is reached.
// Notes:   Expected counts are integer arithmetic on ratio and pulses.
`timescale 1ns/10ps
`default_nettype none
module count_gate_reset_control_tb;
  // ------------------------------------------------------------------
  // Stimulus and tallies
  // ------------------------------------------------------------------
  logic        clock;
  logic        srst       = 1'b1;
  logic [3:0]  reg_addr   = 4'h0;
  logic [31:0] reg_wdata  = 32'h0;
  logic        reg_write  = 1'b0;
  logic        reg_read   = 1'b0;
  logic [31:0] reg_rdata, rd;
  logic [11:0] pins       = 12'h000;   // Sockets, source, interrogation
  logic [2:0]  dsel       = 3'h0;      // Decade carrying the source
  logic [1:0]  ratio;
  logic [7:0]  decade_out;
  logic        preset, inhibit, clr_a, clr_b, strobe, irq;
  logic [31:0] lfsr_r     = 32'h14EEC; // Seed 85740
  int          fail_count = 0;
  int          num_checks = 0;
  int          presets, clears, n, d, s;
  logic        clk_en     = 1'b1;      // Global enable, dropped once
  localparam int WIN      = 2000;      // Short window, end in reach
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  count_gate_reset_control #(.WINDOW_CYC(WIN)) DUT (
    .clock(clock), .srst(srst), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .decade_out(decade_out), .interrogate_in(pins[11:5]),
    .start_input_socket(pins[0]), .stop_input_socket(pins[1]),
    .reset_input_socket_a(pins[2]), .reset_input_socket_b(pins[3]),
    .preset_count_output(preset), .input_inhibit(inhibit), .counter_clear_a(clr_a),
    .counter_clear_b(clr_b), .printer_strobe(strobe), .irq(irq));
  decade_chain_model chain (
    .clock(clock), .srst(srst), .src_pulse(pins[4]), .decade_sel(dsel),
    .input_inhibit(inhibit), .printer_strobe(strobe), .decade_out(decade_out));
  always @(posedge clock) begin
    if (srst) begin
      presets <= 0;
      clears  <= 0;
    end else begin
      if (preset === 1'b1) presets <= presets + 1;
      if ((clr_a & clr_b) === 1'b1) clears <= clears + 1;
    end
  end
  // ------------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------------
  function automatic logic [31:0] lfsr_next(logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  // Settle past the edge so flop updates have landed
  task automatic settle(int c);
    repeat (c) @(posedge clock);
    #1;
  endtask
  task automatic wr(logic [3:0] a, logic [31:0] v);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd_reg(logic [3:0] a);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1 rd = reg_rdata;
  endtask
  // Two cycles high, then low long enough for the synchronisers
  task automatic pulse(logic [11:0] m);
    @(posedge clock);
    pins <= m;
    repeat (2) @(posedge clock);
    pins <= 12'h000;
    settle(5);
  endtask
  task automatic do_reset();
    @(posedge clock);
    srst <= 1'b1;
    repeat (6) @(posedge clock);
    srst <= 1'b0;
  endtask
  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Whole run takes a few thousand cycles
  initial begin
    repeat (40000) @(posedge clock);
    fail_count++;
    wrap_up();
  end
  // ------------------------------------------------------------------
  // Test sequence
  // ------------------------------------------------------------------
  initial begin
    repeat (6) @(posedge clock);
    srst <= 1'b0;
    // Every even address, mapped or not, reads zero after reset
    for (int i = 0; i < 8; i++) begin
      rd_reg(4'(i * 2));
      check("reset value", rd, 32'h0);
    end
    check("inhibit at reset", 32'(inhibit), 32'h1);
    d = count_gate_pkg::RESET_WINDOW_CYC / (count_gate_pkg::CLOCK_MHZ * 1000);
    check("window ms", 32'(d), 32'h32);
    $display("Test reset values done");
    // Random decade and pulse count through each ratio code
    for (int k = 0; k < 8; k++) begin
      lfsr_r = lfsr_next(lfsr_r);
      ratio = 2'(k);
      n = 5 + lfsr_r[2:0];
      do_reset();
      dsel <= lfsr_r[5:3];
      wr(4'h0, 32'({1'b1, 3'h0, lfsr_r[5:3], ratio}));
      repeat (n) pulse(12'h010);
      settle(8);
      d = (ratio == count_gate_pkg::DIV_BY_2) ? 2 : (ratio == count_gate_pkg::DIV_BY_4) ? 4 : 1;
      s = (d == 4) ? 4 * (n % 2) + 8 * ((n / 2) % 2) : (d == 2) ? 8 * (n % 2) : 0;
      check("preset count", 32'(presets), 32'(n / d));
      check("pulses passed", 32'(chain.passed), 32'(n));
      rd_reg(4'h4);
      check("status", rd, 32'(s + 1));
    end
    $display("Test ratios done");
    // Switch closed: first preset stops the count; event, mask, clear
    do_reset();
    dsel <= 3'h0;
    wr(4'hC, 32'h2);
    wr(4'h0, 32'h120);
    repeat (4) pulse(12'h010);
    check("preset routed away", 32'(presets), 32'h0);
    check("pulses passed", 32'(chain.passed), 32'h1);
    check("irq raised", 32'(irq), 32'h1);
    rd_reg(4'h8);
    check("events", rd, 32'h3);
    wr(4'h8, 32'h2);
    rd_reg(4'h8);
    check("events after clear", rd, 32'h1);
    check("irq masked", 32'(irq), 32'h0);
    $display("Test stop on preset done");
    // Each interrogation line, then all at once, gives one strobe
    for (int i = 0; i < 7; i++) pulse(12'(32'h20 << i));
    pulse(12'hFE0);
    check("strobes", 32'(chain.strobes), 32'h8);
    check("no preset while stopped", 32'(presets), 32'h0);
    $display("Test interrogation done");
    // Run state by register and by socket; stop wins a tie
    wr(4'h0, 32'h100);
    settle(4);
    check("run by register", 32'(inhibit), 32'h0);
    wr(4'h0, 32'h300);
    settle(4);
    check("stop beats start", 32'(inhibit), 32'h1);
    pulse(12'h001);
    check("run by socket", 32'(inhibit), 32'h0);
    @(posedge clock) clk_en <= 1'b0;
    pulse(12'h002);
    check("frozen while disabled", 32'(inhibit), 32'h0);
    @(posedge clock) clk_en <= 1'b1;
    pulse(12'h002);
    check("stop by socket", 32'(inhibit), 32'h1);
    pulse(12'h001);
    $display("Test run state done");
    // Reset request stops at once and opens the window; a repeat is ignored
    pulse(12'h008);
    check("stopped by reset", 32'(inhibit), 32'h1);
    rd_reg(4'h4);
    check("window open", rd, 32'h2);
    pulse(12'h004);
    settle(1000);
    rd_reg(4'h4);
    check("window still open", rd, 32'h2);
    check("no clear yet", 32'(clr_a | clr_b), 32'h0);
    // Start inside the window, toggle stage one; the end clears it
    wr(4'h0, 32'h102);
    pulse(12'h010);
    rd_reg(4'h4);
    check("stage one set", rd, 32'h7);
    settle(1100);
    check("clear pulses", 32'(clears), 32'h1);
    check("run kept", 32'(inhibit), 32'h0);
    rd_reg(4'h4);
    check("stages cleared", rd, 32'h1);
    $display("Test reset window done");
    wrap_up();
  end
endmodule
bind count_gate_reset_control count_gate_monitor mon (
  .clock(clock), .srst(srst), .clk_en(clk_en), .interrogate_in(interrogate_in),
  .start_input_socket(start_input_socket), .stop_input_socket(stop_input_socket),
  .reset_input_socket_a(reset_input_socket_a), .reset_input_socket_b(reset_input_socket_b),
  .preset_count_output(preset_count_output), .input_inhibit(input_inhibit),
  .counter_clear_a(counter_clear_a), .counter_clear_b(counter_clear_b),
  .printer_strobe(printer_strobe));
`default_nettype wire
